/* hdl/spcs_core.sv */
// Serial programmed clock source: setting word port, oscillator model and divider.
// Assumes reset is the power-up reset and the host clock is unrelated to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module spcs_core (
    input wire logic clk_sys,             // System clock, 50 MHz
    input wire logic reset,               // Power-up reset, async, active high
    input wire logic clk_en,              // Clock enable, freezes clk_sys-domain state when low; the sck-side port and full flag keep running
    input wire logic sck,                 // Host serial clock, link domain
    input wire logic frame_select_n,      // Frame select pin, active low
    input wire logic shift_data_in,       // Serial data pin
    input wire logic output_enable,       // Async output enable pin
    output logic clk_main,                // Main clock output
    output logic clk_aux,                 // Auxiliary clock output
    output logic powered_down,            // High in shutdown configuration
    output var spcs_pkg::spcs_setting_s active_setting // Applied setting word
);
    logic [15:0] shift_word;
    logic [4:0] bit_count;

    spcs_shift_port u_port (
        .sck(sck),
        .frame_select_n(frame_select_n),
        .shift_data_in(shift_data_in),
        .shift_word(shift_word),
        .bit_count(bit_count)
    );

    // Frame select and link results enter clk_sys through two flops each.
    // Word and full flag are stable once frame select is high, so sampling them
    // after the synchronised rising edge is safe
    logic sen_s1_reg, sen_s2_reg, sen_s3_reg;
    logic [15:0] word_hold_reg;
    logic full_hold_reg;
    logic sen_rise;
    assign sen_rise = sen_s2_reg & ~sen_s3_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sen_s1_reg <= 1'b1;
            sen_s2_reg <= 1'b1;
            sen_s3_reg <= 1'b1;
        end else if (clk_en) begin
            sen_s1_reg <= frame_select_n;
            sen_s2_reg <= sen_s1_reg;
            sen_s3_reg <= sen_s2_reg;
        end
    end

    // Frame select high clears the count at once, so clk_sys could miss the
    // full state; instead a link-side flag records it on each sck rise and
    // holds it while the link clock stands still between frames
    logic full_link_reg;
    always_ff @(posedge sck or posedge reset) begin
        if (reset) begin
            full_link_reg <= 1'b0;
        end else begin
            full_link_reg <= (bit_count >= spcs_pkg::BIT_COUNT_FULL - 5'h01);
        end
    end

    logic full_s1_reg, full_s2_reg;
    logic [15:0] word_s1_reg;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            full_s1_reg <= 1'b0;
            full_s2_reg <= 1'b0;
            word_s1_reg <= spcs_pkg::WORD_RESET;
            word_hold_reg <= spcs_pkg::WORD_RESET;
        end else if (clk_en) begin
            full_s1_reg <= full_link_reg;
            full_s2_reg <= full_s1_reg;
            word_s1_reg <= shift_word;
            word_hold_reg <= word_s1_reg;
        end
    end
    assign full_hold_reg = full_s2_reg;

    // Apply only complete frames; a short one leaves the setting alone
    spcs_pkg::spcs_setting_s setting_reg, setting_next;
    always_comb begin
        setting_next = setting_reg;
        if (sen_rise && full_hold_reg) begin
            setting_next = spcs_pkg::spcs_setting_s'(word_hold_reg);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            setting_reg <= spcs_pkg::spcs_setting_s'(spcs_pkg::WORD_RESET);
        end else if (clk_en) begin
            setting_reg <= setting_next;
        end
    end

    // Oscillator model: phase accumulator adds 1024+fine, so rate spans one octave.
    // A digital model cannot reach 34-68 MHz at 50 MHz; it keeps the ratios only.
    logic [spcs_pkg::ACC_WIDTH:0] acc_reg, acc_next;
    logic [spcs_pkg::DIV_WIDTH-1:0] div_reg, div_next;
    logic osc_tick;
    always_comb begin
        acc_next = {1'b0, acc_reg[spcs_pkg::ACC_WIDTH-1:0]}
            + {2'b01, setting_reg.fine_setting};
        osc_tick = acc_next[spcs_pkg::ACC_WIDTH];
        div_next = osc_tick ? div_reg + 16'h0001 : div_reg;
        if (setting_reg.output_config == spcs_pkg::CNF_SHUTDOWN) begin
            acc_next = '0;
            div_next = div_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acc_reg <= '0;
            div_reg <= 16'h0000;
        end else if (clk_en) begin
            acc_reg <= acc_next;
            div_reg <= div_next;
        end
    end

    // Divide by two to the octave plus one: pick one divider stage
    logic base_wave;
    assign base_wave = div_reg[setting_reg.divider_power_select];

    // Output configuration decode, registered for glitch-free outputs
    logic main_reg, main_next, aux_reg, aux_next;
    always_comb begin
        main_next = 1'b0;
        aux_next = 1'b0;
        case (setting_reg.output_config)
            spcs_pkg::CNF_BOTH: begin
                main_next = base_wave;
                aux_next = ~base_wave;
            end
            spcs_pkg::CNF_AUX_ONLY: begin
                aux_next = base_wave;
            end
            spcs_pkg::CNF_MAIN_ONLY: begin
                main_next = base_wave;
            end
            default: begin
                main_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            main_reg <= 1'b0;
            aux_reg <= 1'b0;
        end else if (clk_en) begin
            main_reg <= main_next;
            aux_reg <= aux_next;
        end
    end

    // Output enable gates combinationally so it acts without any clock
    assign clk_main = main_reg & output_enable;
    assign clk_aux = aux_reg & output_enable;
    assign powered_down = (setting_reg.output_config == spcs_pkg::CNF_SHUTDOWN);
    assign active_setting = setting_reg;

    // Checks
    property p_oe_low;
        @(posedge clk_sys) disable iff (reset) !output_enable |-> (!clk_main && !clk_aux);
    endproperty
    a_oe_low: assert property (p_oe_low) else $error("outputs high while disabled");

    property p_apply;
        @(posedge clk_sys) disable iff (reset) (clk_en && sen_rise && full_hold_reg)
            |=> (setting_reg == spcs_pkg::spcs_setting_s'($past(word_hold_reg)));
    endproperty
    a_apply: assert property (p_apply) else $error("full frame not applied");

    property p_short;
        @(posedge clk_sys) disable iff (reset) !(sen_rise && full_hold_reg) |=> $stable(setting_reg);
    endproperty
    a_short: assert property (p_short) else $error("setting changed without full frame");

    property p_shutdown;
        @(posedge clk_sys) disable iff (reset) powered_down [*2] |-> (!main_reg && !aux_reg);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("output active in shutdown");

    property p_inverted;
        @(posedge clk_sys) disable iff (reset)
            (!reset && clk_en && setting_reg.output_config == spcs_pkg::CNF_BOTH)
            ##1 $stable(setting_reg)
            |-> (main_reg != aux_reg);
    endproperty
    a_inverted: assert property (p_inverted) else $error("aux not inverted");

    property p_main_off;
        @(posedge clk_sys) disable iff (reset)
            (setting_reg.output_config == spcs_pkg::CNF_AUX_ONLY) [*2] |-> !main_reg;
    endproperty
    a_main_off: assert property (p_main_off) else $error("main on in aux-only");

    property p_aux_off;
        @(posedge clk_sys) disable iff (reset)
            (setting_reg.output_config == spcs_pkg::CNF_MAIN_ONLY) [*2] |-> !aux_reg;
    endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux on in main-only");

    // At the top fine setting the oscillator may skip one tick, never two in a row
    property p_tick_fine;
        @(posedge clk_sys) disable iff (reset)
            (clk_en && !powered_down && setting_reg.fine_setting == 10'h3ff && !osc_tick)
            ##1 (clk_en && $stable(setting_reg)) |-> osc_tick;
    endproperty
    a_tick_fine: assert property (p_tick_fine) else $error("top fine setting missed tick");

    c_apply: cover property (@(posedge clk_sys) disable iff (reset) sen_rise && full_hold_reg);
    c_short: cover property (@(posedge clk_sys) disable iff (reset) sen_rise && !full_hold_reg);
    c_shutdown: cover property (@(posedge clk_sys) disable iff (reset) powered_down);
endmodule
`default_nettype wire

/* hdl/spcs_pkg.sv */
// Constants and carrier types for the serial programmed clock source.
// Assumes a 50 MHz system clock and a host-driven three-wire serial port.
package spcs_pkg;
    localparam int WORD_BITS = 16;
    localparam int OCT_MSB = 15;
    localparam int OCT_LSB = 12;
    localparam int FINE_MSB = 11;
    localparam int FINE_LSB = 2;
    localparam int CNF_MSB = 1;
    localparam int CNF_LSB = 0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
    localparam logic [1:0] CNF_BOTH = 2'h0;
    localparam logic [1:0] CNF_AUX_ONLY = 2'h1;
    localparam logic [1:0] CNF_MAIN_ONLY = 2'h2;
    localparam logic [1:0] CNF_SHUTDOWN = 2'h3;
    localparam int FINE_WIDTH = 10;
    localparam int ACC_WIDTH = 11;
    localparam int DIV_WIDTH = 16;

    typedef struct packed {
        logic [3:0] divider_power_select;
        logic [9:0] fine_setting;
        logic [1:0] output_config;
    } spcs_setting_s;
endpackage

/* hdl/spcs_shift_port.sv */
// Serial shift port running on the host's serial clock.
// Assumes the serial clock only toggles while frame_select_n is low.
`timescale 1ns/100ps
`default_nettype none
module spcs_shift_port (
    input wire logic sck,                 // Serial clock from host
    input wire logic frame_select_n,      // Frame select, active low, also clears the count
    input wire logic shift_data_in,       // Serial data
    output logic [15:0] shift_word,       // Shifted word
    output logic [4:0] bit_count          // Bits taken this frame, saturating
);
    logic [15:0] shift_reg, shift_next;
    logic [4:0] count_reg, count_next;

    // Capture MSB first on rising edges only
    always_comb begin
        shift_next = {shift_reg[14:0], shift_data_in};
        count_next = (count_reg == spcs_pkg::BIT_COUNT_FULL) ? count_reg : count_reg + 5'h01;
    end

    // Frame select high resets the count asynchronously, since sck stops between frames
    always_ff @(posedge sck or posedge frame_select_n) begin
        if (frame_select_n) begin
            count_reg <= 5'h00;
        end else begin
            count_reg <= count_next;
        end
    end

    // Data register needs no reset; only a full frame is ever used
    always_ff @(posedge sck) begin
        shift_reg <= shift_next;
    end

    assign shift_word = shift_reg;
    assign bit_count = count_reg;
endmodule
`default_nettype wire

/* tb/spcs_host_model.sv */
// Host controller model driving the three-wire serial setting port.
// Assumes the bench calls send between frames; serial clock is 32 ns.
`timescale 1ns/100ps
`default_nettype none
module spcs_host_model (
    output logic sck,            // Serial clock, still between frames
    output logic frame_select_n, // Frame select, active low
    output logic shift_data_in   // Serial data
);
    // Idle levels from time zero
    initial begin
        sck = 1'b0;
        frame_select_n = 1'b1;
        shift_data_in = 1'b0;
    end
    // Data changes on the falling edge so the rising edge sees a settled bit
    task automatic send(input logic [15:0] word, input int nbits);
        #7 frame_select_n = 1'b0;
        #8;
        for (int i = 0; i < nbits; i++) begin
            shift_data_in = word[15 - i];
            #16 sck = 1'b1;
            #16 sck = 1'b0;
        end
        #16 frame_select_n = 1'b1;
        shift_data_in = ~shift_data_in; // Released line shows no stale bit
        #200;
    endtask
endmodule
`default_nettype wire

/* tb/serial_programmed_clock_source_tb.sv */
// Self-checking bench for the serial programmed clock source core.
// Assumes the host model is the only driver of the serial port.
`timescale 1ns/100ps
`default_nettype none
module serial_programmed_clock_source_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic output_enable = 1'b1;
    wire logic sck, frame_select_n, shift_data_in;
    logic clk_main, clk_aux, powered_down;
    spcs_pkg::spcs_setting_s active_setting;
    int fails = 0;
    int tests_run = 0;
    int c0, c1, c2, na;

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    spcs_host_model u_host (.sck(sck), .frame_select_n(frame_select_n),
        .shift_data_in(shift_data_in));
    spcs_core u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .sck(sck),
        .frame_select_n(frame_select_n), .shift_data_in(shift_data_in),
        .output_enable(output_enable), .clk_main(clk_main), .clk_aux(clk_aux),
        .powered_down(powered_down), .active_setting(active_setting));

    // Comparisons
    task automatic chk_word(input string name, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chk_bit(input string name, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Count rising edges of both outputs, sampled away from the clock edge
    task automatic count_edges(input int n, output int nm, output int na_o);
        logic pm, pa;
        nm = 0;
        na_o = 0;
        @(negedge clk_sys);
        pm = clk_main;
        pa = clk_aux;
        repeat (n) begin
            @(negedge clk_sys);
            nm += int'(clk_main & ~pm);
            na_o += int'(clk_aux & ~pa);
            pm = clk_main;
            pa = clk_aux;
        end
    endtask
    // Full frame, then the fixed apply latency of the port
    task automatic load_word(input logic [15:0] w);
        u_host.send(w, 16);
        repeat (6) @(posedge clk_sys);
        chk_word("active_setting", w, active_setting);
    endtask

    task automatic t_reset();
        chk_word("reset setting", 16'h0000, active_setting);
        count_edges(64, c0, na);
        chk_bit("both run", 1'b1, c0 > 0 && na == c0);
        chk_bit("aux inverted", ~clk_main, clk_aux);
        $display("test reset done");
    endtask
    task automatic t_configs();
        load_word(16'h3abe);
        chk_word("octave", 16'h0003, 16'(active_setting.divider_power_select));
        chk_word("fine", 16'h02af, 16'(active_setting.fine_setting));
        count_edges(512, c0, na);
        chk_bit("main only", 1'b1, c0 > 0 && na == 0);
        load_word(16'h0001);
        count_edges(64, c0, na);
        chk_bit("aux only", 1'b1, c0 == 0 && na > 0);
        u_host.send(16'hffff, 8);
        repeat (6) @(posedge clk_sys);
        chk_word("short frame", 16'h0001, active_setting);
        load_word(16'h0003);
        count_edges(64, c0, na);
        chk_bit("shutdown", 1'b1, powered_down === 1'b1 && c0 == 0 && na == 0);
        $display("test configs done");
    endtask
    task automatic t_freq();
        load_word(16'h0000);
        count_edges(2048, c0, na);
        load_word(16'h1000);
        count_edges(2048, c1, na);
        chk_bit("octave halves", 1'b1, c0 >= 2 * c1 - 1 && c0 <= 2 * c1 + 1);
        load_word(16'h0ffc);
        count_edges(2048, c2, na);
        chk_bit("fine octave", 1'b1, c2 * 10 > c0 * 19 && c2 <= 2 * c0);
        // Aux rises are main falls, so a window that is not whole periods may differ by one
        chk_bit("aux same rate", 1'b1, na >= c2 - 1 && na <= c2 + 1);
        $display("test freq done");
    endtask
    task automatic t_enable();
        @(posedge clk_sys);
        output_enable <= 1'b0;
        #1;
        chk_bit("main forced", 1'b0, clk_main);
        chk_bit("aux forced", 1'b0, clk_aux);
        count_edges(64, c0, na);
        chk_bit("held low", 1'b1, c0 == 0 && na == 0);
        @(posedge clk_sys);
        output_enable <= 1'b1;
        // Clock enable low freezes the divider chain, so no output edges appear
        @(posedge clk_sys);
        clk_en <= 1'b0;
        count_edges(64, c0, na);
        chk_bit("frozen", 1'b1, c0 == 0 && na == 0);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        count_edges(64, c0, na);
        chk_bit("thawed", 1'b1, c0 > 0 && na > 0);
        $display("test enable done");
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_reset();
        t_configs();
        t_freq();
        t_enable();
        conclude();
    end
    // Watchdog, well beyond the roughly 7400 cycles the tests need
    initial begin
        #1000000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
